// ==== ivl_pkg.sv ====
// Package: constants and carriers of the interrupt vector and power block
`default_nettype none
package ivl_pkg;

  // Operating modes
  typedef enum logic [2:0] {
    RUN_MODE      = 3'b000,
    SLEEP_LEVEL_0 = 3'b001,
    SLEEP_LEVEL_1 = 3'b010,
    SLEEP_LEVEL_2 = 3'b011,
    SLEEP_LEVEL_3 = 3'b100,
    SLEEP_LEVEL_4 = 3'b101
  } ivl_mode_e;

  // Register word indexes, byte address is four times the index
  localparam logic [5:0] IDX_IE     = 6'h00;
  localparam logic [5:0] IDX_IE2    = 6'h01;
  localparam logic [5:0] IDX_IFG    = 6'h02;
  localparam logic [5:0] IDX_IFG2   = 6'h03;
  localparam logic [5:0] IDX_POWER  = 6'h04;
  localparam logic [5:0] IDX_STATUS = 6'h05;
  localparam logic [5:0] IDX_FLAGX  = 6'h06;
  localparam logic [1:0] IDX_VEC_HI = 2'h1;

  // Enable byte fields
  localparam int IE_WDT  = 0;
  localparam int IE_OF   = 1;
  localparam int IE_NMI  = 4;
  localparam int IE_ACCV = 5;
  localparam logic [7:0] IE_MASK  = 8'h33;
  localparam logic [7:0] IE_RESET = 8'h00;

  // Flag byte fields
  localparam int IFG_WDT = 0;
  localparam int IFG_OF  = 1;
  localparam int IFG_NMI = 4;
  localparam logic [7:0] IFG_MASK  = 8'h13;
  localparam logic [7:0] IFG_RESET = 8'h02;

  // Vector slots by priority
  localparam logic [3:0] SLOT_RESET = 4'hF;
  localparam logic [3:0] SLOT_NMI   = 4'hE;
  localparam logic [3:0] SLOT_COMP  = 4'hB;
  localparam logic [3:0] SLOT_WDT   = 4'hA;
  localparam logic [3:0] SLOT_TCH0  = 4'h9;
  localparam logic [3:0] SLOT_TOTH  = 4'h8;
  localparam logic [3:0] SLOT_PORT2 = 4'h3;
  localparam logic [3:0] SLOT_PORT1 = 4'h2;
  localparam logic [15:0] VEC_BASE  = 16'hFFE0;
  localparam logic [15:0] SLOT_USED = 16'hCF0C;

  // Peripheral flag levels, held in their modules
  typedef struct packed {
    logic       timer_ch0_flag;
    logic       timer_ch1_flag;
    logic       timer_ch2_flag;
    logic       timer_overflow_flag;
    logic       comparator_flag;
    logic [7:0] port1_pin_flags;
    logic [7:0] port2_pin_flags;
  } ivl_periph_s;

  // One-cycle event pulses
  typedef struct packed {
    logic osc_fault;
    logic pin_nmi;
    logic flash_access;
    logic hard_nmi;
    logic wdt_interval;
    logic wdt_expire;
    logic rst_pin;
    logic flash_key_violation;
  } ivl_event_s;

  // Clock and oscillator gates
  typedef struct packed {
    logic cpu_run;
    logic main_clk_en;
    logic periph_clk_en;
    logic aux_clk_en;
    logic dco_gen_en;
    logic xtal_en;
  } ivl_gate_s;

  // Whole module state
  typedef struct packed {
    logic [15:0][15:0] vec;
    logic [7:0]        ie;
    logic [7:0]        ifg;
    logic              accv;
    logic              hard_nmi;
    logic              rst_pend;
    ivl_mode_e         mode;
    ivl_mode_e         saved;
    logic              a_valid;
    logic              a_write;
    logic              a_map;
    logic [5:0]        a_idx;
    logic [31:0]       hrdata;
    logic              rdy;
    logic              hresp;
    logic              irq_req;
    logic [3:0]        slot;
    logic [15:0]       vaddr;
    logic [15:0]       handler;
    logic              sys_reset;
    ivl_gate_s         gates;
  } ivl_state_s;

endpackage
`default_nettype wire

// ==== ivl_ctrl.sv ====
// Interrupt vectoring and sleep-mode clock control with AHB-Lite registers
//
// The placing of the registers and the AHB-Lite slave port are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none

// Functional notes
// - Vectors fill top words down to FFE0
// - Each vector holds a 16-bit handler address
// - All reset causes use FFFE, priority 15
// - Pin NMI, oscillator, access share FFFC
// - Own enables gate slot 14, GIE not
// - Hard NMI ignores every enable
// - Timer channel 0 at FFF2, priority 9
// - Timer channels 1,2, overflow share FFF0
// - Port 2 flags share FFE6, priority 3
// - Port 1 flags share FFE4, priority 2
// - Timer and port flags stay in peripherals
// - Port 2 takes all eight flags
// - Interrupt wakes, return restores sleep mode
// - Run mode: everything clocked
// - Level 0: CPU, main clock stopped
// - Level 1: oscillator generator off conditionally
// - Level 2: peripheral clock off, generator on
// - Level 3: only auxiliary clock and crystal run
// - Level 4: all off, crystal stopped
// - Enables at bits 0,1,4,5, cleared on PUC
// - PUC sets osc flag; watchdog flag POR/pin
module ivl_ctrl (
  // Clock, reset, enable
  input  wire logic               i_clk,
  input  wire logic               i_rst,
  input  wire logic               i_ce,
  // AHB-Lite slave
  input  wire logic               i_hsel,
  input  wire logic [31:0]        i_haddr,
  input  wire logic [1:0]         i_htrans,
  input  wire logic               i_hwrite,
  input  wire logic [2:0]         i_hsize,
  input  wire logic [31:0]        i_hwdata,
  input  wire logic               i_hready,
  output logic                    o_hreadyout,
  output logic                    o_hresp,
  output logic [31:0]             o_hrdata,
  // CPU side
  input  wire logic               i_gie,
  input  wire logic               i_irq_ack,
  input  wire logic               i_reti,
  output logic                    o_irq_req,
  output logic [3:0]              o_irq_slot,
  output logic [15:0]             o_irq_vec_addr,
  output logic [15:0]             o_vector_pc,
  output logic                    o_sys_reset,
  // Sources
  input  wire ivl_pkg::ivl_periph_s i_periph,
  input  wire ivl_pkg::ivl_event_s  i_ev,
  input  wire logic               i_dco_in_run,
  // Power gates
  output ivl_pkg::ivl_gate_s      o_gates
);

  ivl_pkg::ivl_state_s q;
  ivl_pkg::ivl_state_s d;
  logic        wr;
  logic        puc;
  logic        nmi_soft;
  logic [15:0] req;
  logic [3:0]  top;
  logic [31:0] rd;
  ivl_pkg::ivl_mode_e eff;

  function automatic logic [3:0] prio(input logic [15:0] r);
    logic [3:0] s;
    s = 4'h0;
    for (int k = 0; k < 16; k++) begin
      if (r[k]) begin
        s = 4'(k);
      end
    end
    return s;
  endfunction

  function automatic ivl_pkg::ivl_gate_s gate_of(input ivl_pkg::ivl_mode_e m,
                                                 input logic dco_run);
    ivl_pkg::ivl_gate_s g;
    g = '1;
    unique case (m)
      ivl_pkg::RUN_MODE: begin
        g = '1;
      end
      ivl_pkg::SLEEP_LEVEL_0: begin
        g.cpu_run = 1'b0;
        g.main_clk_en = 1'b0;
      end
      ivl_pkg::SLEEP_LEVEL_1: begin
        g.cpu_run = 1'b0;
        g.main_clk_en = 1'b0;
        g.dco_gen_en = dco_run;
      end
      ivl_pkg::SLEEP_LEVEL_2: begin
        g.cpu_run = 1'b0;
        g.main_clk_en = 1'b0;
        g.periph_clk_en = 1'b0;
      end
      ivl_pkg::SLEEP_LEVEL_3: begin
        g.cpu_run = 1'b0;
        g.main_clk_en = 1'b0;
        g.periph_clk_en = 1'b0;
        g.dco_gen_en = 1'b0;
      end
      ivl_pkg::SLEEP_LEVEL_4: begin
        g = '0;
      end
      default: begin
        g = '1;
      end
    endcase
    return g;
  endfunction

  always_comb begin
    d = q;
    wr = q.a_valid && q.a_write && q.a_map;
    puc = i_ev.rst_pin || i_ev.wdt_expire || i_ev.flash_key_violation;

    // Address phase capture, zero wait states
    d.rdy = 1'b1;
    d.hresp = 1'b0;
    d.a_valid = i_hsel && i_htrans[1] && i_hready;
    d.a_write = i_hwrite;
    d.a_map = (i_haddr[31:8] == 24'h000000) && (i_hsize == 3'b010);
    d.a_idx = i_haddr[7:2];

    // Software writes; hardware sets below win over them
    if (wr) begin
      if (q.a_idx == ivl_pkg::IDX_IE) begin
        d.ie = i_hwdata[7:0] & ivl_pkg::IE_MASK;
      end
      if (q.a_idx == ivl_pkg::IDX_IFG) begin
        d.ifg = i_hwdata[7:0] & ivl_pkg::IFG_MASK;
      end
      if (q.a_idx == ivl_pkg::IDX_FLAGX) begin
        d.accv = i_hwdata[0];
      end
      if (q.a_idx == ivl_pkg::IDX_POWER) begin
        d.mode = (i_hwdata[2:0] > 3'b101) ? ivl_pkg::RUN_MODE :
                 ivl_pkg::ivl_mode_e'(i_hwdata[2:0]);
      end
      if (q.a_idx[5:4] == ivl_pkg::IDX_VEC_HI) begin
        d.vec[q.a_idx[3:0]] = i_hwdata[15:0];
      end
    end

    // Acceptance by the CPU wakes it and keeps the mode to return to
    if (i_irq_ack && q.irq_req) begin
      if (q.slot == ivl_pkg::SLOT_RESET) begin
        d.rst_pend = 1'b0;
      end
      if (q.slot == ivl_pkg::SLOT_NMI) begin
        d.hard_nmi = 1'b0;
      end
      if (q.mode != ivl_pkg::RUN_MODE) begin
        d.saved = q.mode;
        d.mode = ivl_pkg::RUN_MODE;
      end
    end
    // Only one level of sleep is remembered
    if (i_reti) begin
      d.mode = q.saved;
      d.saved = ivl_pkg::RUN_MODE;
    end

    // Hardware events
    if (i_ev.osc_fault) begin
      d.ifg[ivl_pkg::IFG_OF] = 1'b1;
    end
    if (i_ev.pin_nmi) begin
      d.ifg[ivl_pkg::IFG_NMI] = 1'b1;
    end
    if (i_ev.flash_access) begin
      d.accv = 1'b1;
    end
    if (i_ev.hard_nmi) begin
      d.hard_nmi = 1'b1;
    end
    if (i_ev.rst_pin) begin
      d.ifg[ivl_pkg::IFG_WDT] = 1'b0;
    end
    if (i_ev.wdt_interval || i_ev.wdt_expire || i_ev.flash_key_violation) begin
      d.ifg[ivl_pkg::IFG_WDT] = 1'b1;
    end
    if (puc) begin
      d.ie = ivl_pkg::IE_RESET;
      d.ifg[ivl_pkg::IFG_OF] = 1'b1;
      d.accv = 1'b0;
      d.hard_nmi = 1'b0;
      d.rst_pend = 1'b1;
      d.mode = ivl_pkg::RUN_MODE;
      d.saved = ivl_pkg::RUN_MODE;
    end
    d.sys_reset = puc;

    // Request vector; slots without a source stay zero
    nmi_soft = (d.ifg[ivl_pkg::IFG_NMI] && d.ie[ivl_pkg::IE_NMI]) ||
               (d.ifg[ivl_pkg::IFG_OF] && d.ie[ivl_pkg::IE_OF]) ||
               (d.accv && d.ie[ivl_pkg::IE_ACCV]);
    req = 16'h0000;
    req[ivl_pkg::SLOT_RESET] = d.rst_pend;
    req[ivl_pkg::SLOT_NMI] = nmi_soft || d.hard_nmi;
    req[ivl_pkg::SLOT_COMP] = i_gie && i_periph.comparator_flag;
    req[ivl_pkg::SLOT_WDT] = i_gie && d.ifg[ivl_pkg::IFG_WDT] &&
                             d.ie[ivl_pkg::IE_WDT];
    req[ivl_pkg::SLOT_TCH0] = i_gie && i_periph.timer_ch0_flag;
    req[ivl_pkg::SLOT_TOTH] = i_gie && (i_periph.timer_ch1_flag ||
                              i_periph.timer_ch2_flag ||
                              i_periph.timer_overflow_flag);
    req[ivl_pkg::SLOT_PORT2] = i_gie && (|i_periph.port2_pin_flags);
    req[ivl_pkg::SLOT_PORT1] = i_gie && (|i_periph.port1_pin_flags);
    req = req & ivl_pkg::SLOT_USED;
    top = prio(req);

    d.irq_req = |req;
    d.slot = top;
    d.vaddr = ivl_pkg::VEC_BASE + {11'h000, top, 1'b0};
    d.handler = d.vec[top];

    // A pending request keeps the CPU clocked until it is taken
    eff = (|req) ? ivl_pkg::RUN_MODE : d.mode;
    d.gates = gate_of(eff, i_dco_in_run);

    // Read data from the next state, so a write just before is seen
    rd = 32'h00000000;
    unique case (i_haddr[7:2])
      ivl_pkg::IDX_IE:     rd = {24'h000000, d.ie};
      ivl_pkg::IDX_IFG:    rd = {24'h000000, d.ifg};
      ivl_pkg::IDX_POWER:  rd = {25'h0000000, d.saved, 1'b0, d.mode};
      ivl_pkg::IDX_STATUS: rd = {19'h00000, d.gates, 2'b00, d.irq_req, d.slot};
      ivl_pkg::IDX_FLAGX:  rd = {29'h00000000, d.rst_pend, d.hard_nmi, d.accv};
      default: begin
        if (i_haddr[7:6] == ivl_pkg::IDX_VEC_HI) begin
          rd = {16'h0000, d.vec[i_haddr[5:2]]};
        end
      end
    endcase
    if (d.a_valid && !i_hwrite) begin
      d.hrdata = d.a_map ? rd : 32'h00000000;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      q <= '0;
      q.ie <= ivl_pkg::IE_RESET;
      q.ifg <= ivl_pkg::IFG_RESET;
      q.rst_pend <= 1'b1;
      q.mode <= ivl_pkg::RUN_MODE;
      q.saved <= ivl_pkg::RUN_MODE;
      q.rdy <= 1'b1;
      q.sys_reset <= 1'b1;
      q.gates <= '1;
    end else if (i_ce) begin
      q <= d;
    end
  end

  assign o_hreadyout    = q.rdy;
  assign o_hresp        = q.hresp;
  assign o_hrdata       = q.hrdata;
  assign o_irq_req      = q.irq_req;
  assign o_irq_slot     = q.slot;
  assign o_irq_vec_addr = q.vaddr;
  assign o_vector_pc    = q.handler;
  assign o_sys_reset    = q.sys_reset;
  assign o_gates        = q.gates;

  // Checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  logic quiet;
  // A bus write in the same cycle may clear an enable or flag
  assign quiet = !puc && !q.rst_pend && !i_irq_ack && !wr && i_ce;

  sequence s_ack_sleep;
    i_ce && i_irq_ack && q.irq_req && !i_reti && !puc &&
      (q.mode != ivl_pkg::RUN_MODE);
  endsequence

  AST_VEC_ADDR: assert property (o_irq_req |->
    o_irq_vec_addr == (16'hFFE0 + {11'h000, o_irq_slot, 1'b0}))
    else $error("vector address not tied to slot");

  AST_HANDLER: assert property (o_irq_req |->
    o_vector_pc == q.vec[o_irq_slot])
    else $error("handler word not from vector table");

  AST_RESET_TOP: assert property (i_ce && i_ev.rst_pin |=>
    o_irq_req && o_irq_slot == 4'hF && o_sys_reset)
    else $error("reset event not vectored at top slot");

  AST_NMI_NO_GIE: assert property (quiet && !i_gie && !i_ev.hard_nmi &&
    q.ie[4] && q.ifg[4] |=> o_irq_req && o_irq_slot == 4'hE)
    else $error("pin NMI blocked by global enable");

  AST_HARD_NMI: assert property (quiet && i_ev.hard_nmi && q.ie == 8'h00
    |=> o_irq_req && o_irq_slot == 4'hE)
    else $error("hard NMI not taken");

  AST_GIE_GATES: assert property (o_irq_req && o_irq_slot < 4'hE &&
    $past(i_ce) |-> $past(i_gie))
    else $error("maskable slot requested with GIE low");

  AST_PUC_BITS: assert property (i_ce && i_ev.wdt_expire |=>
    q.ie == 8'h00 && q.ifg[1] && q.ifg[0])
    else $error("PUC did not clear enables or set flags");

  AST_WDT_PIN_CLR: assert property (i_ce && i_ev.rst_pin && !i_ev.wdt_interval &&
    !i_ev.wdt_expire && !i_ev.flash_key_violation |=> !q.ifg[0])
    else $error("pin reset did not clear watchdog flag");

  AST_SLEEP_WAKE: assert property (s_ack_sleep |=>
    q.mode == ivl_pkg::RUN_MODE && q.saved == $past(q.mode))
    else $error("wake did not save sleep mode");

  AST_PRIO: assert property (o_irq_req && $past(i_ce) |->
    (($past(req) >> o_irq_slot) == 16'h0001))
    else $error("a higher pending slot was skipped");

  AST_UNUSED_SLOT: assert property (o_irq_req |->
    ((16'hCF0C >> o_irq_slot) & 16'h0001) == 16'h0001)
    else $error("unassigned slot requested");

  AST_LEVEL3: assert property ($past(i_ce) && !$past(|req) &&
    $past(q.mode) == ivl_pkg::SLEEP_LEVEL_3 && $past(d.mode) ==
    ivl_pkg::SLEEP_LEVEL_3 |-> o_gates == 6'b000101)
    else $error("level 3 gates wrong");

  AST_OSC_NMI: assert property (quiet && q.ie[1] && q.ifg[1] |=>
    o_irq_req && o_irq_slot == 4'hE)
    else $error("oscillator fault not vectored at slot 14");

  AST_ACCV_NMI: assert property (quiet && q.ie[5] && q.accv |=>
    o_irq_req && o_irq_slot == 4'hE)
    else $error("access violation not vectored at slot 14");

  // Slot sources; the flags themselves stay in the peripherals
  AST_TIMER0: assert property (o_irq_req && o_irq_slot == 4'h9 && $past(i_ce) |->
    $past(i_periph.timer_ch0_flag))
    else $error("slot 9 without timer channel 0 flag");

  AST_TIMER_OTHER: assert property (o_irq_req && o_irq_slot == 4'h8 && $past(i_ce) |->
    $past(i_periph.timer_ch1_flag || i_periph.timer_ch2_flag || i_periph.timer_overflow_flag))
    else $error("slot 8 without a timer flag");

  AST_PORT2: assert property (o_irq_req && o_irq_slot == 4'h3 && $past(i_ce) |->
    $past(|i_periph.port2_pin_flags))
    else $error("slot 3 without a port 2 flag");

  AST_PORT1: assert property (o_irq_req && o_irq_slot == 4'h2 && $past(i_ce) |->
    $past(|i_periph.port1_pin_flags))
    else $error("slot 2 without a port 1 flag");

  // Gate map per mode, a pending request forces run gating
  AST_WAKE_GATES: assert property ($past(i_ce) && $past(|req) |->
    o_gates == 6'b111111)
    else $error("pending request did not wake clocks");

  AST_RUN_GATES: assert property ($past(i_ce) &&
    $past(d.mode) == ivl_pkg::RUN_MODE |-> o_gates == 6'b111111)
    else $error("run mode gates wrong");

  AST_LEVEL0: assert property ($past(i_ce) && !$past(|req) &&
    $past(d.mode) == ivl_pkg::SLEEP_LEVEL_0 |-> o_gates == 6'b001111)
    else $error("level 0 gates wrong");

  AST_LEVEL1: assert property ($past(i_ce) && !$past(|req) &&
    $past(d.mode) == ivl_pkg::SLEEP_LEVEL_1 |->
    o_gates == {4'b0011, $past(i_dco_in_run), 1'b1})
    else $error("level 1 gates wrong");

  AST_LEVEL2: assert property ($past(i_ce) && !$past(|req) &&
    $past(d.mode) == ivl_pkg::SLEEP_LEVEL_2 |-> o_gates == 6'b000111)
    else $error("level 2 gates wrong");

  AST_LEVEL4: assert property ($past(i_ce) && !$past(|req) &&
    $past(d.mode) == ivl_pkg::SLEEP_LEVEL_4 |-> o_gates == 6'b000000)
    else $error("level 4 gates wrong");

endmodule
`default_nettype wire

// ==== ivl_cpu_model.sv ====
// Behavioural CPU that takes interrupts and returns from them
`timescale 1ns/100ps
`default_nettype none
module ivl_cpu_model (
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  // Controller side
  input  wire logic       i_irq_req,
  output logic            o_irq_ack,
  output logic            o_reti,
  // Bench control
  input  wire logic       i_auto,
  input  wire logic [3:0] i_dly
);
  logic [3:0] wait_q;
  logic [2:0] hand_q;

  // Slow answers wait i_dly cycles; handler lasts five cycles
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_irq_ack <= 1'b0;
      o_reti    <= 1'b0;
      wait_q    <= 4'h0;
      hand_q    <= 3'h0;
    end else begin
      o_irq_ack <= 1'b0;
      o_reti    <= (hand_q == 3'h1);
      if (hand_q != 3'h0) begin
        hand_q <= hand_q - 3'h1;
      end else if (i_auto && i_irq_req && !o_irq_ack && !o_reti) begin
        if (wait_q >= i_dly) begin
          o_irq_ack <= 1'b1;
          hand_q    <= 3'h5;
          wait_q    <= 4'h0;
        end else begin
          wait_q <= wait_q + 4'h1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ==== test_irq_vector_lowpower_ctrl.sv ====
// Self-checking bench of the interrupt vector and sleep control block
`timescale 1ns/100ps
`default_nettype none
module test_irq_vector_lowpower_ctrl;
  typedef struct {
    string       what;
    logic [1:0]  kind;
    logic [31:0] exp;
    logic [31:0] msk;
  } ivl_note_s;

  logic                i_clk  = 1'b0;
  logic                i_rst  = 1'b1;
  logic                hsel   = 1'b0;
  logic                hwrite = 1'b0;
  logic                gie    = 1'b0;
  logic                digital_osc    = 1'b0;
  logic                auto   = 1'b0;
  logic                ce     = 1'b1;
  logic                snap   = 1'b0;
  logic                rd_pend = 1'b0;
  logic [31:0]         haddr  = 32'h0;
  logic [31:0]         hwdata = 32'h0;
  logic [1:0]          htrans = 2'h0;
  logic [2:0]          hsize  = 3'h2;
  logic [3:0]          dly    = 4'h0;
  ivl_pkg::ivl_periph_s periph = '0;
  ivl_pkg::ivl_event_s  ev     = '0;
  wire logic           hready;
  wire logic           hresp;
  wire logic           req;
  wire logic           ack;
  wire logic           reti;
  wire logic [31:0]    hrdata;
  wire logic [3:0]     slot;
  wire logic [15:0]    vaddr;
  wire logic [15:0]    vpc;
  wire ivl_pkg::ivl_gate_s gates;
  logic [15:0]         vt [16];
  logic [31:0]         seen;
  ivl_note_s           sb [$];
  ivl_note_s           note;
  int                  num_errors = 0;
  int                  checked = 0;
  int                  seed = 32'h2F95A5A6;
  int                  m;
  logic [7:0]          puc [3] = '{8'h04, 8'h02, 8'h01};
  logic [7:0]          nev [3] = '{8'h80, 8'h40, 8'h20};
  logic [7:0]          nie [3] = '{8'h02, 8'h10, 8'h20};
  logic [31:0]         ncl [3] = '{32'h08, 32'h08, 32'h18};
  logic [20:0]         pri [4] = '{21'h180101, 21'h080101, 21'h000101, 21'h000100};
  logic [3:0]          psl [4] = '{4'h9, 4'h8, 4'h3, 4'h2};

  always #2.5 i_clk = ~i_clk;

  ivl_ctrl i_dut (
    .i_clk          (i_clk),
    .i_rst          (i_rst),
    .i_ce           (ce),
    .i_hsel         (hsel),
    .i_haddr        (haddr),
    .i_htrans       (htrans),
    .i_hwrite       (hwrite),
    .i_hsize        (hsize),
    .i_hwdata       (hwdata),
    .i_hready       (hready),
    .o_hreadyout    (hready),
    .o_hresp        (hresp),
    .o_hrdata       (hrdata),
    .i_gie          (gie),
    .i_irq_ack      (ack),
    .i_reti         (reti),
    .o_irq_req      (req),
    .o_irq_slot     (slot),
    .o_irq_vec_addr (vaddr),
    .o_vector_pc    (vpc),
    .o_sys_reset    (),
    .i_periph       (periph),
    .i_ev           (ev),
    .i_dco_in_run   (digital_osc),
    .o_gates        (gates)
  );

  ivl_cpu_model i_cpu (
    .i_clk     (i_clk),
    .i_rst     (i_rst),
    .i_irq_req (req),
    .o_irq_ack (ack),
    .o_reti    (reti),
    .i_auto    (auto),
    .i_dly     (dly)
  );

  function automatic logic [31:0] irqv(input logic [3:0] s);
    return {11'h000, 1'b1, s, 16'hFFE0 + {11'h000, s, 1'b0}};
  endfunction

  function automatic logic [5:0] gexp(input int md, input logic d);
    case (md)
      0: return 6'h3F;
      1: return 6'h0F;
      2: return {4'h3, d, 1'b1};
      3: return 6'h07;
      4: return 6'h05;
      default: return 6'h00;
    endcase
  endfunction

  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
  endtask

  // Single word transfer; hready is sampled, never assumed
  task automatic bus(input logic [31:0] a, input logic wr, input logic [31:0] wd,
                     input logic [31:0] e);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= 3'h2;
    if (!wr) sb.push_back('{"rdata", 2'd0, e, 32'hFFFFFFFF});
    do @(posedge i_clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge i_clk); while (hready !== 1'b1);
  endtask

  // Two edges first so registered outputs have settled
  task automatic chk(input string w, input logic [1:0] k, input logic [31:0] e,
                     input logic [31:0] mk);
    tick(2);
    sb.push_back('{w, k, e, mk});
    snap <= 1'b1;
    tick(1);
    snap <= 1'b0;
  endtask

  task automatic pulse(input ivl_pkg::ivl_event_s e);
    ev <= e;
    tick(1);
    ev <= '0;
    tick(1);
  endtask

  task automatic ackall();
    auto <= 1'b1;
    tick(12);
    auto <= 1'b0;
    tick(1);
  endtask

  task automatic summarize();
    $display("checked %0d num_errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Mid-cycle sampling keeps the compare clear of edge races
  always @(negedge i_clk) begin
    if ((rd_pend || snap) && sb.size() > 0) begin
      note = sb.pop_front();
      seen = (note.kind == 2'd0) ? hrdata :
             (note.kind == 2'd1) ? {11'h000, req, slot, vaddr} :
             (note.kind == 2'd2) ? {26'h0, gates} : {16'h0000, vpc};
      checked++;
      if ((seen & note.msk) !== note.exp) begin
        num_errors++;
        $display("[ERR] %s exp %h seen %h", note.what, note.exp, seen & note.msk);
      end
    end
    if (rd_pend && hresp !== 1'b0) begin
      num_errors++;
      $display("[ERR] hresp exp 0 seen %b", hresp);
    end
    rd_pend = hsel && htrans == 2'h2 && !hwrite;
  end

  initial begin
    tick(5000);
    num_errors++;
    summarize();
  end

  initial begin
    tick(12);
    i_rst <= 1'b0;
    chk("rst_vec", 2'd1, irqv(4'hF), 32'h1FFFFF);
    bus(32'h00, 1'b0, 32'h0, 32'h00);
    bus(32'h08, 1'b0, 32'h0, 32'h02);
    bus(32'h00, 1'b1, 32'hFFFFFFFF, 32'h0);
    bus(32'h00, 1'b0, 32'h0, 32'h33);
    bus(32'h04, 1'b0, 32'h0, 32'h00);
    bus(32'h00, 1'b1, 32'h0, 32'h0);
    for (int k = 0; k < 16; k++) begin
      vt[k] = 16'($random(seed));
      bus(32'h40 + 32'(4 * k), 1'b1, {16'h0000, vt[k]}, 32'h0);
    end
    for (int k = 0; k < 16; k++) begin
      bus(32'h40 + 32'(4 * k), 1'b0, 32'h0, {16'h0000, vt[k]});
    end
    chk("vec_pc", 2'd3, {16'h0000, vt[15]}, 32'hFFFF);
    ackall();
    chk("rst_clr", 2'd1, 32'h0, 32'h100000);
    // Every other reset cause must land on the same top slot
    for (int i = 0; i < 3; i++) begin
      pulse(puc[i]);
      chk("puc_vec", 2'd1, irqv(4'hF), 32'h1FFFFF);
      ackall();
    end
    for (int i = 0; i < 3; i++) begin
      pulse(nev[i]);
      chk("nmi_off", 2'd1, 32'h0, 32'h100000);
      bus(32'h00, 1'b1, {24'h0, nie[i]}, 32'h0);
      chk("nmi_vec", 2'd1, irqv(4'hE), 32'h1FFFFF);
      bus(32'h00, 1'b1, 32'h0, 32'h0);
      bus(ncl[i], 1'b1, 32'h0, 32'h0);
    end
    pulse(8'h10);
    chk("hard_nmi", 2'd1, irqv(4'hE), 32'h1FFFFF);
    ackall();
    chk("hard_clr", 2'd1, 32'h0, 32'h100000);
    // Frozen block must drop an event seen while the enable is low
    ce <= 1'b0;
    pulse(8'h10);
    chk("ce_hold", 2'd1, 32'h0, 32'h100000);
    ce <= 1'b1;
    for (int j = 0; j < 21; j++) begin
      periph <= 21'h1 << j;
      chk("no_gie", 2'd1, 32'h0, 32'h100000);
      gie <= 1'b1;
      chk("mask_vec", 2'd1, irqv((j == 20) ? 4'h9 : (j >= 17) ? 4'h8 : (j == 16) ? 4'hB :
          (j >= 8) ? 4'h2 : 4'h3), 32'h1FFFFF);
      gie <= 1'b0;
    end
    gie <= 1'b1;
    periph <= pri[0];
    pulse(8'h10);
    chk("pri_nmi", 2'd1, irqv(4'hE), 32'h1FFFFF);
    ackall();
    for (int i = 0; i < 4; i++) begin
      periph <= pri[i];
      chk("pri_vec", 2'd1, irqv(psl[i]), 32'h1FFFFF);
    end
    periph <= '0;
    for (int k = 0; k < 7; k++) begin
      m = (k == 6) ? 2 : k;
      digital_osc <= (k == 6);
      bus(32'h10, 1'b1, 32'(m), 32'h0);
      chk("gates", 2'd2, {26'h0, gexp(m, k == 6)}, 32'h3F);
      bus(32'h10, 1'b0, 32'h0, 32'(m));
    end
    // Slow partner: the wake must outlast a delayed ack
    bus(32'h10, 1'b1, 32'h4, 32'h0);
    dly <= 4'h3;
    auto <= 1'b1;
    pulse(8'h10);
    for (int t = 0; t < 20 && gates.cpu_run !== 1'b1; t++) @(negedge i_clk);
    @(posedge i_clk);
    chk("wake", 2'd2, 32'h3F, 32'h3F);
    for (int t = 0; t < 40 && reti !== 1'b1; t++) @(negedge i_clk);
    @(posedge i_clk);
    auto <= 1'b0;
    chk("restore", 2'd2, 32'h05, 32'h3F);
    bus(32'h10, 1'b0, 32'h0, 32'h4);
    summarize();
  end
endmodule
`default_nettype wire
